// File: common/trc_pkg.sv
// Purpose: Constants and types for the timer reload and compare value block
// Assumes: 32-bit register port, one word per register
// Notes:   Summary of operation
//
// Summary of operation
// - Counter holds still while reload limit is zero
// - Reload limit 32 bits wide, 16 narrow
// - Input channel captures counter on capture event
// - Output channel compares value against counter continuously
// - Preload off: written value compares immediately
// - Preload on: value becomes active at update
// - Channel one value 32 or 16 bits wide
// - Channels two to four behave like one
// - Counter 32 bits wide, else 16 bits
package trc_pkg;
   // ==========================================
   // Register offsets
   localparam logic [7:0]  OFS_RELOAD_LIMIT    = 8'h2c;
   localparam logic [7:0]  OFS_CH1_VALUE       = 8'h34;
   localparam logic [7:0]  OFS_CH2_VALUE       = 8'h38;
   localparam logic [7:0]  OFS_CH3_VALUE       = 8'h3c;
   localparam logic [7:0]  OFS_CH4_VALUE       = 8'h40;
   localparam logic [7:0]  OFS_CTRL            = 8'h50;
   localparam logic [7:0]  OFS_COUNTER         = 8'h54;
   // ==========================================
   // Reset values
   localparam logic [31:0] RST_RELOAD_LIMIT    = 32'hffffffff;
   localparam logic [31:0] RST_CH_VALUE        = 32'h00000000;
   localparam logic [31:0] RST_COUNTER         = 32'h00000000;
   localparam logic [31:0] RST_CTRL            = 32'h00000000;
   // ==========================================
   // Control register fields
   localparam int          CTRL_MODE_POS       = 0;
   localparam int          CTRL_PRELOAD_POS    = 4;
   localparam int          CTRL_COUNT_EN_POS   = 8;
   localparam int          NUM_CH              = 4;
   // ==========================================
   // Types
   typedef enum logic {TRC_MODE_OUTPUT, TRC_MODE_INPUT} trc_mode_t;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } trc_bus_req_t;
endpackage

// File: rtl/trc_timer_values.sv
// Purpose: Reload limit and four capture/compare value registers of a timer
// Assumes: Synchronous active-low reset, single 50 MHz clock
// Notes:   Wide instance uses 32-bit values, narrow instance 16-bit
`timescale 1ns/100ps
module trc_timer_values
   import trc_pkg::*;
#(
   parameter int WIDE = 1
)
(
   // Clock and reset
   input  wire logic            ref_clk,
   input  wire logic            rst_n,
   // Register port
   input  wire trc_bus_req_t    bus_req,
   output logic [31:0]          rd_data,
   // Channel events and outputs
   input  wire logic [3:0]      capture_event,
   output logic [3:0]           channel_compare_output,
   output logic                 update_event,
   output logic [31:0]          counter_value
);
   localparam logic [31:0] VAL_MASK = (WIDE != 0) ? 32'hffffffff : 32'h0000ffff;

   // ==========================================
   // Helpers
   function automatic logic [31:0] trim(input logic [31:0] v);
      trim = v & VAL_MASK;
   endfunction

   logic [31:0] reload_limit_value_r;
   logic [31:0] counter_r;
   logic [31:0] ctrl_r;
   logic [31:0] shadow_r [NUM_CH];
   logic [31:0] active_r [NUM_CH];
   logic [31:0] rd_data_r;
   logic [3:0]  cmp_r;
   logic        upd_r;
   logic        counting;
   logic        wrap;

   assign counting = ctrl_r[CTRL_COUNT_EN_POS] && (reload_limit_value_r != 32'h0);
   assign wrap     = counting && (counter_r >= reload_limit_value_r);

   // ==========================================
   // Reload limit
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         reload_limit_value_r <= trim(RST_RELOAD_LIMIT);
      else if (bus_req.wr && bus_req.addr == OFS_RELOAD_LIMIT)
         reload_limit_value_r <= trim(bus_req.wdata);
   end

   // ==========================================
   // Control
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         ctrl_r <= RST_CTRL;
      else if (bus_req.wr && bus_req.addr == OFS_CTRL)
         ctrl_r <= bus_req.wdata & 32'h0000010f | (bus_req.wdata & 32'h000000f0);
   end

   // ==========================================
   // Counter
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         counter_r <= trim(RST_COUNTER);
      else if (bus_req.wr && bus_req.addr == OFS_COUNTER)
         counter_r <= trim(bus_req.wdata);
      else if (wrap)
         counter_r <= 32'h0;
      else if (counting)
         counter_r <= trim(counter_r + 32'h1);
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         upd_r <= 1'b0;
      else
         upd_r <= wrap;
   end

   // ==========================================
   // Channel values
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < NUM_CH; i++)
         begin
            shadow_r[i] <= RST_CH_VALUE;
            active_r[i] <= RST_CH_VALUE;
         end
      end
      else
      begin
         for (int i = 0; i < NUM_CH; i++)
         begin
            if (ctrl_r[CTRL_MODE_POS + i] == TRC_MODE_INPUT)
            begin
               if (capture_event[i])
               begin
                  shadow_r[i] <= counter_r;
                  active_r[i] <= counter_r;
               end
               else if (bus_req.wr && bus_req.addr == OFS_CH1_VALUE + 8'(4 * i))
               begin
                  shadow_r[i] <= trim(bus_req.wdata);
                  active_r[i] <= trim(bus_req.wdata);
               end
            end
            else
            begin
               if (bus_req.wr && bus_req.addr == OFS_CH1_VALUE + 8'(4 * i))
               begin
                  shadow_r[i] <= trim(bus_req.wdata);
                  if (!ctrl_r[CTRL_PRELOAD_POS + i])
                     active_r[i] <= trim(bus_req.wdata);
               end
               if (wrap && ctrl_r[CTRL_PRELOAD_POS + i])
               begin
                  if (bus_req.wr && bus_req.addr == OFS_CH1_VALUE + 8'(4 * i))
                     active_r[i] <= trim(bus_req.wdata);
                  else
                     active_r[i] <= shadow_r[i];
               end
            end
         end
      end
   end

   // ==========================================
   // Compare outputs
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         cmp_r <= 4'h0;
      else
         for (int i = 0; i < NUM_CH; i++)
            cmp_r[i] <= (ctrl_r[CTRL_MODE_POS + i] == TRC_MODE_OUTPUT)
                        && (counter_r < active_r[i]);
   end

   // ==========================================
   // Read data
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         rd_data_r <= 32'h0;
      else if (bus_req.rd)
      begin
         if (bus_req.addr == OFS_RELOAD_LIMIT)
            rd_data_r <= reload_limit_value_r;
         else if (bus_req.addr == OFS_CH1_VALUE)
            rd_data_r <= shadow_r[0];
         else if (bus_req.addr == OFS_CH2_VALUE)
            rd_data_r <= shadow_r[1];
         else if (bus_req.addr == OFS_CH3_VALUE)
            rd_data_r <= shadow_r[2];
         else if (bus_req.addr == OFS_CH4_VALUE)
            rd_data_r <= shadow_r[3];
         else if (bus_req.addr == OFS_CTRL)
            rd_data_r <= ctrl_r;
         else if (bus_req.addr == OFS_COUNTER)
            rd_data_r <= counter_r;
         else
            rd_data_r <= 32'h0;
      end
      else
         rd_data_r <= 32'h0;
   end

   assign rd_data                = rd_data_r;
   assign channel_compare_output = cmp_r;
   assign update_event           = upd_r;
   assign counter_value          = counter_r;
endmodule

// File: verification/trc_timer_values_assertions.sv
// Purpose: Port checks for the timer value block
// Assumes: Register shadows follow bus writes
// Notes:   Bound to every trc_timer_values
`timescale 1ns/100ps
module trc_chk
   import trc_pkg::*;
#(parameter int WIDE = 1)
(
   // Clock and reset
   input wire logic         ref_clk,
   input wire logic         rst_n,
   // Watched ports
   input wire trc_bus_req_t bus_req,
   input wire logic [31:0]  rd_data,
   input wire logic [3:0]   capture_event,
   input wire logic [3:0]   channel_compare_output,
   input wire logic         update_event,
   input wire logic [31:0]  counter_value
);
   // ==========
   // Shadows
   logic [31:0] lim_r;
   logic [8:0]  ctl_r;
   always_ff @(posedge ref_clk)
      if (!rst_n) lim_r <= (WIDE != 0) ? RST_RELOAD_LIMIT : {16'h0, RST_RELOAD_LIMIT[15:0]};
      else if (bus_req.wr && bus_req.addr == OFS_RELOAD_LIMIT)
         lim_r <= (WIDE != 0) ? bus_req.wdata : {16'h0, bus_req.wdata[15:0]};
   always_ff @(posedge ref_clk)
      if (!rst_n) ctl_r <= '0;
      else if (bus_req.wr && bus_req.addr == OFS_CTRL) ctl_r <= bus_req.wdata[8:0];
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // ==========
   // Properties
   property p_frz; lim_r == 0 && !bus_req.wr |=> $stable(counter_value); endproperty
   a_frz: assert property (p_frz) else $error("counter moved");
   property p_lim; bus_req.rd && bus_req.addr == OFS_RELOAD_LIMIT |=> rd_data == lim_r; endproperty
   a_lim: assert property (p_lim) else $error("limit read");
   property p_cap; ctl_r[0] && capture_event[0] ##1 bus_req.rd && bus_req.addr == OFS_CH1_VALUE
      |=> rd_data == $past(counter_value, 2); endproperty
   a_cap: assert property (p_cap) else $error("capture");
   property p_inm; &ctl_r[3:0] |=> channel_compare_output == 4'h0; endproperty
   a_inm: assert property (p_inm) else $error("input mode out");
   property p_ch1; bus_req.wr && bus_req.addr == OFS_CH1_VALUE && !ctl_r[0] ##1 !bus_req.wr
      ##1 bus_req.rd && bus_req.addr == OFS_CH1_VALUE |=> rd_data == $past(bus_req.wdata, 3);
   endproperty
   a_ch1: assert property (p_ch1) else $error("ch1 value");
   property p_wrp; ctl_r[8] && lim_r != 0 && counter_value >= lim_r && !bus_req.wr
      |=> counter_value == 32'h0 && update_event; endproperty
   a_wrp: assert property (p_wrp) else $error("wrap");
   property p_upd; update_event |=> !update_event; endproperty
   a_upd: assert property (p_upd) else $error("update width");
   property p_wid; WIDE != 0 || counter_value[31:16] == 16'h0; endproperty
   a_wid: assert property (p_wid) else $error("counter width");
endmodule
bind trc_timer_values trc_chk #(.WIDE(WIDE)) u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
   .bus_req(bus_req), .rd_data(rd_data), .capture_event(capture_event),
   .channel_compare_output(channel_compare_output), .update_event(update_event),
   .counter_value(counter_value));

// File: verification/tb_top.sv
// Purpose: Self-checking bench for the timer value block
// Assumes: Wide instance, counter frozen while values are probed
// Notes:   Random data from a shift register
`timescale 1ns/100ps
module tb_top
   import trc_pkg::*;
;
   // ==========
   // Signals
   logic         ref_clk = 0;
   logic         rst_n   = 0;
   logic         upd;
   logic [3:0]   cap = 0;
   logic [3:0]   cmp;
   logic [31:0]  rd_data, cnt;
   logic [31:0]  v = 32'h8f92e5aa;
   trc_bus_req_t req = '0;
   int           fail_count = 0, tests_run = 0, i;
   logic [7:0]   ofs [5] = '{OFS_RELOAD_LIMIT, OFS_CH1_VALUE, OFS_CH2_VALUE, OFS_CH3_VALUE,
                            OFS_CH4_VALUE};
   always #10 ref_clk = ~ref_clk;
   trc_timer_values #(.WIDE(1)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(req),
      .rd_data(rd_data), .capture_event(cap), .channel_compare_output(cmp),
      .update_event(upd), .counter_value(cnt));
   function logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function logic [31:0] lt(input logic [31:0] c, input logic [31:0] x);
      return {31'h0, c < x};
   endfunction
   task results;
      $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk) req <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk) req <= '0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk) req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge ref_clk) req <= '0;
      #1 chk(rd_data, e);
   endtask
   task st(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // ==========
   // Scenarios
   initial
   begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (i = 0; i < 5; i++) rd(ofs[i], i == 0 ? RST_RELOAD_LIMIT : RST_CH_VALUE);
      wr(8'h44, 32'h1);
      rd(8'h44, 32'h0);
      for (i = 0; i < 5; i++)
      begin
         v = nx(v);
         wr(ofs[i], v);
         rd(ofs[i], v);
      end
      wr(OFS_CTRL, 32'hf);
      v = nx(v);
      wr(OFS_COUNTER, v);
      rd(OFS_COUNTER, v);
      @(posedge ref_clk) cap <= 4'hf;
      for (i = 1; i < 5; i++) rd(ofs[i], v);
      @(posedge ref_clk) cap <= 4'h0;
      #1;
      chk({28'h0, cmp}, 32'h0);
      wr(OFS_CTRL, 32'h0);
      wr(OFS_COUNTER, 32'h5);
      wr(OFS_CH1_VALUE, 32'h6);
      st(2);
      chk({31'h0, cmp[0]}, lt(32'h5, 32'h6));
      wr(OFS_CH1_VALUE, 32'h4);
      st(2);
      chk({31'h0, cmp[0]}, lt(32'h5, 32'h4));
      wr(OFS_CTRL, 32'hf0);
      wr(OFS_CH1_VALUE, 32'h9);
      st(2);
      chk({31'h0, cmp[0]}, lt(32'h5, 32'h4));
      wr(OFS_RELOAD_LIMIT, 32'h5);
      wr(OFS_CTRL, 32'h1f0);
      for (i = 0; i < 50 && upd !== 1'b1; i++) st(1);
      if (i == 50)
      begin
         fail_count++;
         results;
      end
      chk(cnt, 32'h0);
      chk({31'h0, upd}, 32'h1);
      st(2);
      chk({31'h0, upd}, 32'h0);
      chk({31'h0, cmp[0]}, lt(32'h5, 32'h9));
      wr(OFS_RELOAD_LIMIT, 32'h0);
      st(1);
      v = cnt;
      st(5);
      chk(cnt, v);
      results;
   end
endmodule
